// ===== common/rate_pll_pkg.sv
// Purpose: Shared constants and carriers for the transmitter PLL index and rate divide block
// Assumes: One clock, synchronous user ports
// Notes: Divider codes are shared by the control input and the readout output
package rate_pll_pkg;
    localparam int IDX_W = 2;
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;
    localparam logic [1:0] DIV_RSVD = 2'h3;
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam int REFCLK_MIN = 1;
    localparam int REFCLK_MAX = 10;
    localparam int REFCLK_W = 4;
    localparam logic [IDX_W-1:0] PLL_IDX_SECOND = 2'h1;
    // Image word written toward a channel
    typedef struct packed {
        logic [IDX_W-1:0] pll_idx;
        logic [REFCLK_W-1:0] refclk_id;
        logic [7:0] tx_cfg;
        logic [7:0] rx_cfg;
    } image_word_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CFG = 2'b01,
        ST_DONE = 2'b10
    } cfg_state_e;
endpackage

// ===== design/pll_index_select.sv
// Purpose: Choose the transmitter PLL index written into a channel
// Assumes: Port presence is fixed by parameters at build time
// Notes: Pure selection, no storage
`timescale 1ns/1ps
module pll_index_select import rate_pll_pkg::*; #(
    parameter bit HAS_OVR_IDX = 1'b1,
    parameter bit HAS_OVR_EN = 1'b1
) (
    input wire logic [IDX_W-1:0] image_idx,
    input wire logic [IDX_W-1:0] ovr_idx,
    input wire logic ovr_en,
    output logic [IDX_W-1:0] chosen_idx,
    output logic ovr_used
);
    // Enable port absent with the index port present means the override index always applies
    wire use_ovr = HAS_OVR_IDX && (!HAS_OVR_EN || ovr_en);
    assign ovr_used = use_ovr;
    assign chosen_idx = use_ovr ? ovr_idx : image_idx;
endmodule

// ===== design/tx_pll_index_and_rate_divide.sv
// Purpose: Transmitter PLL index override and per channel local divider control
// Assumes: User ports synchronous to mclk; one transaction at a time
// Notes: Divider state per channel held in flip-flops indexed by address
// Notes on behaviour
// - Override index used when both ports exist and enable is high.
// - Image index used when both ports exist and enable is low.
// - Index port alone always overrides; no ports means image index used.
// - Index override never touches receiver settings of the channel.
// - Image PLL index replaced by override while writing the channel.
// - At most ten reference clocks, identified 1 through 10.
// - Rate divide changes only the addressed transmitter divider to 1, 2, 4.
// - Rate divide only for non-bonded channels on local multiplier PLLs.
// - Two-bit rate control input selects the addressed channel divider.
// - Optional readout returns current divider of addressed channel.
// - Readout uses the same code as the control input.
// - Code 10 selects divide by four.
// - Code 01 means divide by two on both control and readout.
// - Rate transactions use port values only, no image read.
`timescale 1ns/1ps
module tx_pll_index_and_rate_divide import rate_pll_pkg::*; #(
    parameter int CHANNELS = 4,
    parameter int ADDR_W = 2,
    parameter bit HAS_OVR_IDX = 1'b1,
    parameter bit HAS_OVR_EN = 1'b1,
    parameter bit HAS_RATE_OUT = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] channel_addr,
    input wire logic image_write,
    input wire image_word_s image_in,
    input wire logic [IDX_W-1:0] pll_idx_ovr,
    input wire logic pll_idx_ovr_en,
    input wire logic rate_write,
    input wire logic rate_read,
    input wire logic [1:0] rate_ctrl,
    input wire logic [CHANNELS-1:0] chan_bonded,
    input wire logic [CHANNELS-1:0] chan_local_pll,
    output logic busy,
    output logic reconfig_done,
    output logic chan_write,
    output logic [ADDR_W-1:0] chan_addr_out,
    output image_word_s chan_word,
    output logic [1:0] rate_out,
    output logic rate_out_valid,
    output logic rate_refused,
    output logic image_refused,
    output logic [2*CHANNELS-1:0] tx_div_codes
);
    cfg_state_e state;
    cfg_state_e next_state;
    logic [1:0] div_code [CHANNELS];
    image_word_s word_q;
    logic [ADDR_W-1:0] addr_q;
    logic [IDX_W-1:0] chosen_idx;

    // Legal divider code and reference clock identifier range
    function automatic logic code_ok(input logic [1:0] c);
        return c != DIV_RSVD;
    endfunction
    function automatic logic refclk_ok(input logic [REFCLK_W-1:0] r);
        return r >= REFCLK_W'(REFCLK_MIN) && r <= REFCLK_W'(REFCLK_MAX);
    endfunction

    wire in_range = 32'(channel_addr) < CHANNELS;
    wire [ADDR_W-1:0] idx = channel_addr;
    // Bonded or foreign-PLL channels cannot be divided locally
    wire chan_ok = in_range && !chan_bonded[idx] && chan_local_pll[idx];
    wire idle = state == ST_IDLE;
    // Rate write is taken straight from the ports; no image fetch needed
    wire rate_take = idle && rate_write && chan_ok && code_ok(rate_ctrl);
    wire rate_bad = idle && rate_write && !rate_take;
    wire read_take = idle && rate_read && !rate_write && in_range && HAS_RATE_OUT;
    wire img_take = idle && image_write && !rate_write && !rate_read
        && refclk_ok(image_in.refclk_id);
    wire img_bad = idle && image_write && !rate_write && !rate_read && !img_take;

    pll_index_select #(
        .HAS_OVR_IDX(HAS_OVR_IDX),
        .HAS_OVR_EN(HAS_OVR_EN)
    ) u_sel (
        .image_idx(word_q.pll_idx),
        .ovr_idx(pll_idx_ovr),
        .ovr_en(pll_idx_ovr_en),
        .chosen_idx(chosen_idx),
        .ovr_used()
    );

    // Next state: image write takes one configuration cycle, then done
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (img_take) begin
                    next_state = ST_CFG;
                end
            end
            ST_CFG: next_state = ST_DONE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Latch the image; override index is sampled late, hence held by user
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= '0;
            addr_q <= '0;
        end else if (img_take) begin
            word_q <= image_in;
            addr_q <= channel_addr;
        end
    end

    // Channel write: only the PLL index field is replaced; rx field passes untouched
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chan_write <= 1'b0;
            chan_word <= '0;
            chan_addr_out <= '0;
        end else begin
            chan_write <= state == ST_CFG;
            if (state == ST_CFG) begin
                chan_word <= '{pll_idx: chosen_idx, refclk_id: word_q.refclk_id,
                               tx_cfg: word_q.tx_cfg, rx_cfg: word_q.rx_cfg};
                chan_addr_out <= addr_q;
            end
        end
    end

    // Per channel divider storage; only the addressed entry changes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                div_code[i] <= DIV_RESET;
            end
        end else if (rate_take) begin
            div_code[idx] <= rate_ctrl;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_div
            assign tx_div_codes[2*g +: 2] = div_code[g];
        end
    endgenerate

    // Readout and status pulses
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rate_out <= DIV_BY1;
            rate_out_valid <= 1'b0;
            reconfig_done <= 1'b0;
            rate_refused <= 1'b0;
            image_refused <= 1'b0;
        end else begin
            rate_out_valid <= read_take;
            if (read_take) begin
                rate_out <= div_code[idx];
            end
            reconfig_done <= state == ST_CFG || rate_take;
            rate_refused <= rate_bad;
            image_refused <= img_bad;
        end
    end

    assign busy = !idle;

    // Assertions
    sequence s_img_start;
        img_take;
    endsequence
    sequence s_img_finish;
        ##2 chan_write && reconfig_done;
    endsequence
    a_img_write_seq: assert property (@(posedge mclk) disable iff (!rst_n)
        s_img_start |-> s_img_finish) else $error("image write not completed in 2 cycles");
    a_ovr_index_used: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ST_CFG && HAS_OVR_IDX && HAS_OVR_EN && pll_idx_ovr_en
        |=> chan_word.pll_idx == $past(pll_idx_ovr)) else $error("override index not written");
    a_image_index_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ST_CFG && HAS_OVR_EN && !pll_idx_ovr_en
        |=> chan_word.pll_idx == $past(word_q.pll_idx)) else $error("image index lost");
    // Builds missing the index port or the enable port: the written index follows port presence alone
    a_no_en_port: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ST_CFG && !(HAS_OVR_IDX && HAS_OVR_EN)
        |=> chan_word.pll_idx == (HAS_OVR_IDX ? $past(pll_idx_ovr) : $past(word_q.pll_idx)))
        else $error("index source wrong");
    a_rx_untouched: assert property (@(posedge mclk) disable iff (!rst_n)
        state == ST_CFG |=> chan_word.rx_cfg == $past(word_q.rx_cfg))
        else $error("receiver settings altered");
    a_rate_store: assert property (@(posedge mclk) disable iff (!rst_n)
        rate_take |=> div_code[$past(idx)] == $past(rate_ctrl) && reconfig_done)
        else $error("divider not stored");
    a_rate_legal: assert property (@(posedge mclk) disable iff (!rst_n)
        rate_write && idle && (rate_ctrl == DIV_RSVD || !chan_ok) |=> rate_refused)
        else $error("illegal rate accepted");
    a_readback_code: assert property (@(posedge mclk) disable iff (!rst_n)
        read_take |=> rate_out_valid && rate_out == div_code[$past(idx)])
        else $error("readout mismatch");
    // An image naming an unknown reference clock is refused and starts nothing
    a_refclk_range: assert property (@(posedge mclk) disable iff (!rst_n)
        idle && image_write && !rate_write && !rate_read
        && (image_in.refclk_id < REFCLK_MIN || image_in.refclk_id > REFCLK_MAX)
        |=> image_refused && !busy)
        else $error("refclk id out of range accepted");
endmodule

// ===== tb/ovr_partner.sv
// Purpose: User-side model owning the PLL index override levels
// Assumes: Bench stages requests on req_idx and req_en
// Notes: Levels move only while idle, never inside a reconfiguration
`timescale 1ns/1ps
module ovr_partner import rate_pll_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic busy,
    input wire logic [IDX_W-1:0] req_idx,
    input wire logic req_en,
    output logic [IDX_W-1:0] pll_idx_ovr,
    output logic pll_idx_ovr_en
);
    // Hold through busy so the controller never samples a moving index
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pll_idx_ovr <= '0;
            pll_idx_ovr_en <= 1'b0;
        end else if (!busy) begin
            pll_idx_ovr <= req_idx;
            pll_idx_ovr_en <= req_en;
        end
    end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for PLL index override and rate divide
// Assumes: Four channels, all optional ports present
// Notes: Channel 2 bonded and channel 3 off its local PLL, both must refuse
`timescale 1ns/1ps
module testbench import rate_pll_pkg::*;;
    logic mclk, rst_n, image_write, req_en, rate_write, rate_read, pll_idx_ovr_en;
    logic busy, reconfig_done, chan_write, rate_out_valid, rate_refused, image_refused;
    logic [1:0] channel_addr, req_idx, rate_ctrl, pll_idx_ovr, chan_addr_out, rate_out;
    logic [3:0] chan_bonded, chan_local_pll;
    logic [7:0] tx_div_codes, divs;
    image_word_s image_in, chan_word;
    int miscompares, checks_done;

    ovr_partner user (.mclk(mclk), .rst_n(rst_n), .busy(busy), .req_idx(req_idx),
        .req_en(req_en), .pll_idx_ovr(pll_idx_ovr), .pll_idx_ovr_en(pll_idx_ovr_en));
    tx_pll_index_and_rate_divide uut (.mclk(mclk), .rst_n(rst_n),
        .channel_addr(channel_addr), .image_write(image_write), .image_in(image_in),
        .pll_idx_ovr(pll_idx_ovr), .pll_idx_ovr_en(pll_idx_ovr_en),
        .rate_write(rate_write), .rate_read(rate_read), .rate_ctrl(rate_ctrl),
        .chan_bonded(chan_bonded), .chan_local_pll(chan_local_pll), .busy(busy),
        .reconfig_done(reconfig_done), .chan_write(chan_write),
        .chan_addr_out(chan_addr_out), .chan_word(chan_word), .rate_out(rate_out),
        .rate_out_valid(rate_out_valid), .rate_refused(rate_refused),
        .image_refused(image_refused), .tx_div_codes(tx_div_codes));

    // Free-running 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Inputs always move 1 ns after the rising edge
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Image write; bounded wait on completion or refusal
    task automatic img_wr(input logic [1:0] a, input logic [1:0] idx, input logic [3:0] rc,
                          input logic [1:0] exp_idx, input logic ok);
        int i;
        image_word_s w;
        w = '{pll_idx: idx, refclk_id: rc, tx_cfg: 8'h5a, rx_cfg: 8'hc3};
        channel_addr = a;
        image_in = w;
        image_write = 1'b1;
        tick;
        image_write = 1'b0;
        for (i = 0; i < 6 && chan_write !== 1'b1 && image_refused !== 1'b1; i++) tick;
        if (i == 6) begin
            miscompares++;
            wrap_up;
        end
        chk("image_refused", 32'(!ok), 32'(image_refused));
        w.pll_idx = exp_idx;
        if (ok) chk("chan_word", 32'(w), 32'(chan_word));
        if (ok) chk("reconfig_done", 32'h1, 32'(reconfig_done));
        if (ok) chk("chan_addr_out", 32'(a), 32'(chan_addr_out));
        for (i = 0; i < 6 && busy !== 1'b0; i++) tick;
        // A busy flag that never drops is counted here as a mismatch
        chk("busy", 32'h0, 32'(busy));
        tick;
    endtask

    task automatic rate_wr(input logic [1:0] a, input logic [1:0] code, input logic ok);
        channel_addr = a;
        rate_ctrl = code;
        rate_write = 1'b1;
        tick;
        rate_write = 1'b0;
        chk("rate_refused", 32'(!ok), 32'(rate_refused));
        chk("reconfig_done", 32'(ok), 32'(reconfig_done));
        if (ok) divs[2*a +: 2] = code;
        chk("tx_div_codes", 32'(divs), 32'(tx_div_codes));
        tick;
    endtask

    task automatic rate_rd(input logic [1:0] a);
        channel_addr = a;
        rate_read = 1'b1;
        tick;
        rate_read = 1'b0;
        chk("rate_out_valid", 32'h1, 32'(rate_out_valid));
        chk("rate_out", 32'(divs[2*a +: 2]), 32'(rate_out));
        tick;
    endtask

    // Reset, every divider code, rate refusals, override off and on, then reference clock refusals
    initial begin
        int k;
        rst_n = 1'b0;
        {channel_addr, image_write, req_idx, req_en, rate_write, rate_read, rate_ctrl} = '0;
        image_in = '0;
        chan_bonded = 4'h4;
        chan_local_pll = 4'h7;
        divs = 8'h00;
        miscompares = 0;
        checks_done = 0;
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        chk("div reset", 32'h0, 32'(tx_div_codes));
        for (k = 0; k < 4; k++) begin
            rate_wr(2'h1, k[1:0], k != 3);
            rate_rd(2'h1);
        end
        rate_wr(2'h0, DIV_BY4, 1'b1);
        rate_rd(2'h0);
        rate_wr(2'h2, DIV_BY2, 1'b0);
        rate_wr(2'h3, DIV_BY2, 1'b0);
        req_idx = PLL_IDX_SECOND;
        tick;
        img_wr(2'h2, 2'h0, 4'h1, 2'h0, 1'b1);
        req_en = 1'b1;
        tick;
        img_wr(2'h3, 2'h0, 4'ha, PLL_IDX_SECOND, 1'b1);
        img_wr(2'h1, 2'h2, 4'h0, 2'h0, 1'b0);
        img_wr(2'h1, 2'h2, 4'hb, 2'h0, 1'b0);
        wrap_up;
    end
endmodule
